// ===== pkg/tmc_cfg.svh
// Offsets, field positions, reset values and select codes of the test bank.
// Assumes nothing; included by name wherever the bank's constants are needed.
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

`define TMC_ADDR_ACT 8'h03
`define TMC_ADDR_BUF 8'h04
`define TMC_ADDR_RDY 8'h05
`define TMC_ADDR_ASEL 8'h06

`define TMC_BIT_TIP 0
`define TMC_BIT_TON 1
`define TMC_BIT_TOP 2
`define TMC_BIT_CLR 3
`define TMC_BIT_VALID 0

`define TMC_RESET_VALUE 8'h00

`define TMC_ASEL_WIDTH 6
`define TMC_ASEL_GND 6'h00
`define TMC_ASEL_FIRST 6'h01
`define TMC_ASEL_SPARE 6'h0a
`define TMC_ASEL_LAST 6'h11

`endif

// ===== pkg/tmc_pkg.sv
// Types shared by the test bank files.
// Assumes tmc_cfg.svh is on the include path.
`include "tmc_cfg.svh"
package tmc_pkg;
    typedef logic [7:0] tmc_byte_type;
    typedef logic [`TMC_ASEL_WIDTH-1:0] tmc_asel_type;
endpackage

// ===== design/tmc_byte_reg.sv
// One storage register of the test bank with host write and local set.
// Assumes a synchronised active-low reset on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"
module tmc_byte_reg
    import tmc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic set_en,
    input wire logic [WIDTH-1:0] set_data,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] next_q;

    // Local set wins over a host write in the same cycle
    always_comb begin
        next_q = q;
        if (set_en) begin
            next_q = set_data;
        end else if (wr_en) begin
            next_q = wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= WIDTH'(`TMC_RESET_VALUE);
        end else begin
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// ===== design/tmc_test_bank.sv
// Test pin routing, communication buffer and analog test select registers.
// Assumes the serial test interface presents byte accesses on clk.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"
module tmc_test_bank
    import tmc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic test_wr_en,
    input wire logic test_rd_en,
    input wire logic [7:0] test_addr,
    input wire logic [7:0] test_wdata,
    output logic [7:0] test_rdata,
    output logic test_rvalid,
    input wire logic cpu_buf_load,
    input wire logic [7:0] cpu_buf_data,
    output logic [7:0] comm_buffer,
    output logic comm_data_valid,
    output logic test_input_pos_enable,
    output logic test_output_neg_enable,
    output logic test_output_pos_enable,
    output logic clear_onewire_errors,
    output logic analog_out_ground,
    output logic analog_neg_spare_ground,
    output logic [`TMC_ASEL_WIDTH-1:0] analog_test_out_select_bits
);
    logic rst_meta_n;
    logic rst_n;
    tmc_byte_type act_q;
    tmc_byte_type rdy_q;
    tmc_byte_type asel_q;
    tmc_byte_type rdy_set;
    tmc_byte_type next_rdata;
    logic next_rvalid;
    logic wr_act;
    logic wr_buf;
    logic wr_rdy;
    logic wr_asel;
    tmc_asel_type asel_f;
    logic next_ground;
    logic next_spare;
    tmc_asel_type next_route;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // decode covers only the test space
    assign wr_act = test_wr_en && (test_addr == `TMC_ADDR_ACT);
    assign wr_buf = test_wr_en && (test_addr == `TMC_ADDR_BUF);
    assign wr_rdy = test_wr_en && (test_addr == `TMC_ADDR_RDY);
    assign wr_asel = test_wr_en && (test_addr == `TMC_ADDR_ASEL);

    tmc_byte_reg #(.WIDTH(8)) u_act (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_act),
        .wr_data(test_wdata),
        .set_en(1'b0),
        .set_data(`TMC_RESET_VALUE),
        .q(act_q)
    );

    // processor only loads data, never addresses registers
    // buffer written by host or processor
    tmc_byte_reg #(.WIDTH(8)) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_buf),
        .wr_data(test_wdata),
        .set_en(cpu_buf_load),
        .set_data(cpu_buf_data),
        .q(comm_buffer)
    );

    // processor load sets ready, winning over host clear
    always_comb begin
        rdy_set = rdy_q;
        rdy_set[`TMC_BIT_VALID] = 1'b1;
    end

    tmc_byte_reg #(.WIDTH(8)) u_rdy (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_rdy),
        .wr_data(test_wdata),
        .set_en(cpu_buf_load),
        .set_data(rdy_set),
        .q(rdy_q)
    );

    tmc_byte_reg #(.WIDTH(8)) u_asel (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_asel),
        .wr_data(test_wdata),
        .set_en(1'b0),
        .set_data(`TMC_RESET_VALUE),
        .q(asel_q)
    );

    assign test_input_pos_enable = act_q[`TMC_BIT_TIP];
    assign test_output_neg_enable = act_q[`TMC_BIT_TON];
    assign test_output_pos_enable = act_q[`TMC_BIT_TOP];
    // error clear held while bit set
    assign clear_onewire_errors = act_q[`TMC_BIT_CLR];
    assign comm_data_valid = rdy_q[`TMC_BIT_VALID];

    // decode select into routing; undefined codes ground
    assign asel_f = asel_q[`TMC_ASEL_WIDTH-1:0];
    always_comb begin
        next_ground = 1'b1;
        next_spare = 1'b0;
        next_route = `TMC_ASEL_GND;
        if (asel_f >= `TMC_ASEL_FIRST && asel_f <= `TMC_ASEL_LAST) begin
            next_ground = 1'b0;
            next_route = asel_f;
            next_spare = (asel_f >= `TMC_ASEL_SPARE);
        end
    end

    // reads return every stored bit; unmapped reads zero
    always_comb begin
        next_rvalid = test_rd_en;
        next_rdata = 8'h00;
        if (test_rd_en) begin
            case (test_addr)
                `TMC_ADDR_ACT: next_rdata = act_q;
                `TMC_ADDR_BUF: next_rdata = comm_buffer;
                `TMC_ADDR_RDY: next_rdata = rdy_q;
                `TMC_ADDR_ASEL: next_rdata = asel_q;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_rdata <= 8'h00;
            test_rvalid <= 1'b0;
            analog_out_ground <= 1'b1;
            analog_neg_spare_ground <= 1'b0;
            analog_test_out_select_bits <= `TMC_ASEL_GND;
        end else begin
            test_rdata <= next_rdata;
            test_rvalid <= next_rvalid;
            analog_out_ground <= next_ground;
            analog_neg_spare_ground <= next_spare;
            analog_test_out_select_bits <= next_route;
        end
    end

    sequence s_act_write;
        test_wr_en && test_addr == `TMC_ADDR_ACT;
    endsequence

    // Write, one quiet cycle, then a read of the same register
    sequence s_act_readback;
        s_act_write ##1 !test_wr_en ##1 (test_rd_en && !test_wr_en &&
            test_addr == `TMC_ADDR_ACT);
    endsequence

    property p_pin2;
        @(posedge clk) disable iff (!rst_n)
        s_act_write |=> test_input_pos_enable == $past(test_wdata[0]);
    endproperty
    a_pin2: assert property (p_pin2) else $error("pin 2 routing wrong");

    property p_pin4;
        @(posedge clk) disable iff (!rst_n)
        s_act_write |=> test_output_neg_enable == $past(test_wdata[1]);
    endproperty
    a_pin4: assert property (p_pin4) else $error("pin 4 routing wrong");

    property p_pin3;
        @(posedge clk) disable iff (!rst_n)
        s_act_write |=> test_output_pos_enable == $past(test_wdata[2]);
    endproperty
    a_pin3: assert property (p_pin3) else $error("pin 3 routing wrong");

    property p_clr;
        @(posedge clk) disable iff (!rst_n)
        $changed(clear_onewire_errors) |-> $past(wr_act);
    endproperty
    a_clr: assert property (p_clr) else $error("error clear moved alone");

    property p_act_rb;
        @(posedge clk) disable iff (!rst_n)
        s_act_readback |=> test_rvalid && test_rdata == $past(test_wdata, 3);
    endproperty
    a_act_rb: assert property (p_act_rb) else $error("act readback bad");

    property p_buf_rb;
        @(posedge clk) disable iff (!rst_n)
        (wr_buf && !cpu_buf_load) |=> comm_buffer == $past(test_wdata);
    endproperty
    a_buf_rb: assert property (p_buf_rb) else $error("buffer not stored");

    property p_ready;
        @(posedge clk) disable iff (!rst_n)
        cpu_buf_load |=> comm_data_valid && comm_buffer == $past(cpu_buf_data);
    endproperty
    a_ready: assert property (p_ready) else $error("ready not set");

    property p_gnd;
        @(posedge clk) disable iff (!rst_n)
        (asel_f == `TMC_ASEL_GND) |=> analog_out_ground &&
            analog_test_out_select_bits == `TMC_ASEL_GND;
    endproperty
    a_gnd: assert property (p_gnd) else $error("select zero not ground");

    property p_spare;
        @(posedge clk) disable iff (!rst_n)
        (asel_f >= 6'h0a && asel_f <= 6'h11) |=> analog_neg_spare_ground &&
            !analog_out_ground && analog_test_out_select_bits == $past(asel_f);
    endproperty
    a_spare: assert property (p_spare) else $error("spare routing bad");

    property p_unmapped;
        @(posedge clk) disable iff (!rst_n)
        (test_rd_en && (test_addr < 8'h03 || test_addr > 8'h06)) |=>
            test_rvalid && test_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read");
endmodule
`default_nettype wire

// ===== sim/tmc_host_model.sv
// Host side of the serial test port: single byte writes and reads.
// Assumes the bench calls wr and rd from a process running on clk.
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
    input wire logic clk,
    output var logic test_wr_en,
    output var logic test_rd_en,
    output var logic [7:0] test_addr,
    output var logic [7:0] test_wdata,
    input wire logic [7:0] test_rdata,
    input wire logic test_rvalid
);
    initial begin
        test_wr_en = 1'b0;
        test_rd_en = 1'b0;
        test_addr = 8'h00;
        test_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        test_addr = a;
        test_wdata = d;
        test_wr_en = 1'b1;
        @(negedge clk);
        test_wr_en = 1'b0;
        test_addr = ~a;
        test_wdata = ~d;
    endtask
    // Answer is taken one cycle after the strobe, unknown if not valid
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        test_addr = a;
        test_rd_en = 1'b1;
        @(negedge clk);
        test_rd_en = 1'b0;
        test_addr = ~a;
        d = (test_rvalid === 1'b1) ? test_rdata : 8'hxx;
    endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench of the test register bank with a host model.
// Assumes the bank, its package and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tmc_pkg::*;
    logic clk, resetn, wr_en, rd_en, rvalid, load, valid, ground, spare;
    logic tip, ton, top, clr;
    logic [7:0] addr, wdata, rdata, ldata, buf_q, d, r;
    logic [5:0] sel;
    int bad_count, comparisons, seed, i;
    tmc_host_model host (.clk(clk), .test_wr_en(wr_en), .test_rd_en(rd_en),
        .test_addr(addr), .test_wdata(wdata), .test_rdata(rdata),
        .test_rvalid(rvalid));
    tmc_test_bank dut (.clk(clk), .resetn(resetn), .test_wr_en(wr_en),
        .test_rd_en(rd_en), .test_addr(addr), .test_wdata(wdata),
        .test_rdata(rdata), .test_rvalid(rvalid), .cpu_buf_load(load),
        .cpu_buf_data(ldata), .comm_buffer(buf_q), .comm_data_valid(valid),
        .test_input_pos_enable(tip), .test_output_neg_enable(ton),
        .test_output_pos_enable(top), .clear_onewire_errors(clr),
        .analog_out_ground(ground), .analog_neg_spare_ground(spare),
        .analog_test_out_select_bits(sel));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic f_gnd(input logic [5:0] c);
        return (c == 6'h00) || (c > 6'h11);
    endfunction
    function automatic logic f_spare(input logic [5:0] c);
        return (c >= 6'h0a) && (c <= 6'h11);
    endfunction
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, r);
        chk("read", e, r);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic do_reset;
        @(negedge clk);
        resetn = 1'b0;
        repeat (20) @(negedge clk);
        chk("rst_pins", 8'h10, {3'h0, ground, clr, top, ton, tip});
        resetn = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    initial begin
        #(25 * 20000);
        bad_count++;
        report_and_stop();
    end
    initial begin
        seed = 83;
        resetn = 1'b0;
        load = 1'b0;
        ldata = 8'h00;
        do_reset();
        rd_chk(8'h03, 8'h00);
        rd_chk(8'h04, 8'h00);
        rd_chk(8'h05, 8'h00);
        rd_chk(8'h06, 8'h00);
        for (i = 0; i < 16; i++) begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            host.wr(8'h03, d);
            chk("act_pins", {4'h0, d[3:0]}, {4'h0, clr, top, ton, tip});
            rd_chk(8'h03, d);
        end
        for (i = 0; i < 64; i++) begin
            d = {2'($random(seed)), 6'(i)};
            host.wr(8'h06, d);
            @(negedge clk);
            chk("gnd", {7'h0, f_gnd(d[5:0])}, {7'h0, ground});
            chk("spare", {7'h0, f_spare(d[5:0])}, {7'h0, spare});
            chk("sel", f_gnd(d[5:0]) ? 8'h00 : {2'h0, d[5:0]},
                {2'h0, sel});
            rd_chk(8'h06, d);
        end
        for (i = 0; i < 8; i++) begin
            host.wr(8'h05, 8'h00);
            chk("valid_clr", 8'h00, {7'h0, valid});
            d = 8'($random(seed));
            @(negedge clk);
            load = 1'b1;
            ldata = d;
            @(negedge clk);
            load = 1'b0;
            ldata = ~d;
            chk("buf", d, buf_q);
            rd_chk(8'h05, 8'h01);
            rd_chk(8'h04, d);
            d = 8'($random(seed));
            host.wr(8'h04, d);
            chk("buf_host", d, buf_q);
        end
        host.wr(8'h03, 8'h5a);
        host.wr(8'h07, 8'hff);
        host.wr(8'h02, 8'hff);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'hff, 8'h00);
        rd_chk(8'h03, 8'h5a);
        do_reset();
        rd_chk(8'h03, 8'h00);
        rd_chk(8'h04, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
